// ---- include/drr_pkg.sv ----
// Constants of the deserializer's address and reset control registers.
// Assumes an I2C target engine elsewhere that turns bus transfers into byte accesses.
// Function
// - Own 7-bit target address lives in bits 7:1 of the address register, reset 0x60.
// - Select bit 0 low uses strapped address; high lets the programmed address win.
// - Writing 1 to reset register bit 5 powers down analog; writing 0 powers it back up.
// - Power-down bit is written only by local port writes; remote writes ignored, but a remote full reset clears it.
// - Bit 1 resets digital logic but keeps registers, then clears itself.
// - Bit 0 resets digital logic and all registers to defaults, then clears itself.
package drr_pkg;
  localparam int unsigned REG_ADDR_W        = 8;
  localparam int unsigned REG_DATA_W        = 8;
  localparam int unsigned TARGET_ADDR_W     = 7;
  localparam logic [7:0]  OFS_TARGET_ADDR   = 8'h00;
  localparam logic [7:0]  OFS_RESET_POWER   = 8'h01;
  localparam int unsigned TA_ADDR_MSB       = 7;
  localparam int unsigned TA_ADDR_LSB       = 1;
  localparam int unsigned TA_SELECT_BIT     = 0;
  localparam int unsigned RP_POWER_DOWN_BIT = 5;
  localparam int unsigned RP_LOGIC_RST_BIT  = 1;
  localparam int unsigned RP_FULL_RST_BIT   = 0;
  localparam logic [6:0]  TA_ADDR_RESET     = 7'h60;
  localparam logic        TA_SELECT_RESET   = 1'h0;
  localparam logic        RP_POWER_RESET    = 1'h0;
  localparam logic [7:0]  UNMAPPED_RDATA    = 8'h00;
  localparam int unsigned SYNC_STAGES       = 2;

  typedef enum logic [2:0] {
    DRR_RST_IDLE  = 3'b001,
    DRR_RST_LOGIC = 3'b010,
    DRR_RST_FULL  = 3'b100
  } drr_rst_state_t;
endpackage

// ---- rtl/drr_regs.sv ----
// Address selection and reset/power control registers of the deserializer.
// Assumes a byte access port from the I2C target engine, with a local/remote source flag.
`timescale 1ns/1ps
`default_nettype none
module drr_regs #(
  parameter int unsigned ADDR_W = drr_pkg::TARGET_ADDR_W
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic                           reg_wr_en,
  input  wire logic                           reg_wr_local,
  input  wire logic                           reg_rd_en,
  input  wire logic [drr_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [drr_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic [ADDR_W-1:0]              address_strap_input,
  output var  logic [drr_pkg::REG_DATA_W-1:0] reg_rdata,
  output var  logic                           reg_rd_valid,
  output var  logic [ADDR_W-1:0]              active_target_address,
  output var  logic                           analog_power_down,
  output var  logic                           logic_reset_pulse,
  output var  logic                           register_reset_pulse
);
  import drr_pkg::*;

  function automatic logic hit(input logic [REG_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Full reset wins when both reset bits arrive in one byte
  function automatic drr_rst_state_t rst_request(input logic [REG_DATA_W-1:0] wdata);
    drr_rst_state_t kind;
    kind = DRR_RST_IDLE;
    if (wdata[RP_FULL_RST_BIT]) begin
      kind = DRR_RST_FULL;
    end else if (wdata[RP_LOGIC_RST_BIT]) begin
      kind = DRR_RST_LOGIC;
    end
    rst_request = kind;
  endfunction

  // Byte image of the address register
  function automatic logic [REG_DATA_W-1:0] pack_target(input logic [ADDR_W-1:0] addr, input logic sel);
    logic [REG_DATA_W-1:0] word;
    word                          = UNMAPPED_RDATA;
    word[TA_ADDR_MSB:TA_ADDR_LSB] = addr;
    word[TA_SELECT_BIT]           = sel;
    pack_target = word;
  endfunction

  // Byte image of the reset register; reserved bits read zero
  function automatic logic [REG_DATA_W-1:0] pack_reset(input logic pd, input drr_rst_state_t st);
    logic [REG_DATA_W-1:0] word;
    word                    = UNMAPPED_RDATA;
    word[RP_POWER_DOWN_BIT] = pd;
    word[RP_LOGIC_RST_BIT]  = (st == DRR_RST_LOGIC);
    word[RP_FULL_RST_BIT]   = (st == DRR_RST_FULL);
    pack_reset = word;
  endfunction

  // Programmed address wins only when the select bit is set
  function automatic logic [ADDR_W-1:0] pick_address(input logic              sel,
                                                     input logic [ADDR_W-1:0] prog,
                                                     input logic [ADDR_W-1:0] strap);
    if (sel) begin
      pick_address = prog;
    end else begin
      pick_address = strap;
    end
  endfunction

  logic [ADDR_W-1:0]  strapped_address_value;
  logic [ADDR_W-1:0]  target_addr_reg;
  logic               address_source_select_reg;
  logic               power_down_reg;
  drr_rst_state_t     rst_state_reg;
  drr_rst_state_t     rst_state_next;
  logic               wr_target;
  logic               wr_reset;
  logic               full_rst;
  logic [ADDR_W-1:0]  active_addr_next;
  logic [7:0]         rdata_next;

  // Strap pins come from outside the clock domain
  drr_sync #(
    .WIDTH(ADDR_W)
  ) i_drr_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (address_strap_input),
    .sync_out (strapped_address_value)
  );

  assign wr_target = reg_wr_en && hit(reg_addr, OFS_TARGET_ADDR);
  assign wr_reset  = reg_wr_en && hit(reg_addr, OFS_RESET_POWER);
  assign full_rst  = (rst_state_reg == DRR_RST_FULL);

  // Full reset takes priority when both reset bits are written together
  always_comb begin
    rst_state_next = DRR_RST_IDLE;
    if (wr_reset) begin
      rst_state_next = rst_request(reg_wdata);
    end
  end

  // Each reset state lasts exactly one cycle, so the bits clear themselves
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rst_state_reg <= DRR_RST_IDLE;
    end else begin
      case (rst_state_reg)
        DRR_RST_IDLE:  rst_state_reg <= rst_state_next;
        DRR_RST_LOGIC: rst_state_reg <= DRR_RST_IDLE;
        DRR_RST_FULL:  rst_state_reg <= DRR_RST_IDLE;
        default:       rst_state_reg <= DRR_RST_IDLE;
      endcase
    end
  end

  // Pulses line up with the reset state; both reset logic, only one the registers
  // Writes during a reset cycle start nothing new
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      logic_reset_pulse <= 1'b0;
    end else begin
      logic_reset_pulse <= (rst_state_reg == DRR_RST_IDLE) && (rst_state_next != DRR_RST_IDLE);
    end
  end

  // Only the full reset reaches the configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      register_reset_pulse <= 1'b0;
    end else begin
      register_reset_pulse <= (rst_state_reg == DRR_RST_IDLE) && (rst_state_next == DRR_RST_FULL);
    end
  end

  // Register reset wins over a write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b || full_rst) begin
      target_addr_reg <= TA_ADDR_RESET;
    end else if (wr_target) begin
      target_addr_reg <= reg_wdata[TA_ADDR_MSB:TA_ADDR_LSB];
    end
  end

  // Select falls back to the strap on full reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b || full_rst) begin
      address_source_select_reg <= TA_SELECT_RESET;
    end else if (wr_target) begin
      address_source_select_reg <= reg_wdata[TA_SELECT_BIT];
    end
  end

  // Remote writes leave the power-down bit untouched unless they request a full reset, which clears it
  always_ff @(posedge ref_clk) begin
    if (!rst_b || full_rst) begin
      power_down_reg <= RP_POWER_RESET;
    end else if (wr_reset && reg_wr_local) begin
      power_down_reg <= reg_wdata[RP_POWER_DOWN_BIT];
    end
  end

  always_comb begin
    active_addr_next = pick_address(address_source_select_reg, target_addr_reg, strapped_address_value);
  end

  // Registered so the address never glitches while the select bit flips
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      active_target_address <= TA_ADDR_RESET;
    end else begin
      active_target_address <= active_addr_next;
    end
  end

  // One cycle behind the register; the analog side is slow anyway
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      analog_power_down <= RP_POWER_RESET;
    end else begin
      analog_power_down <= power_down_reg;
    end
  end

  // Reset bits read one only while their pulse is still pending
  always_comb begin
    rdata_next = UNMAPPED_RDATA;
    if (hit(reg_addr, OFS_TARGET_ADDR)) begin
      rdata_next = pack_target(target_addr_reg, address_source_select_reg);
    end else if (hit(reg_addr, OFS_RESET_POWER)) begin
      rdata_next = pack_reset(power_down_reg, rst_state_reg);
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= UNMAPPED_RDATA;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_next;
    end
  end

  // Valid is a one-cycle answer to each read strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/drr_sync.sv ----
// Multi-bit two-flop synchroniser for slow static levels such as straps.
// Assumes each bit changes rarely; no coherency across bits is promised.
`timescale 1ns/1ps
`default_nettype none
module drr_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/drr_host.sv ----
// Host model issuing single byte accesses.
// Assumes one caller process at a time.
`timescale 1ns/1ps
`default_nettype none
module drr_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  output var  logic       reg_wr_en,
  output var  logic       reg_wr_local,
  output var  logic       reg_rd_en,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_wr_en, reg_wr_local, reg_rd_en, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] dv, input logic loc);
    @(posedge ref_clk) #1;
    {reg_wr_en, reg_wr_local, reg_addr, reg_wdata} = {1'b1, loc, a, dv};
    @(posedge ref_clk) #1;
    reg_wr_en = 1'b0;
    reg_wdata = ~dv; // Stale data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge ref_clk) #1;
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(posedge ref_clk) #1;
    reg_rd_en = 1'b0;
    dv = reg_rd_valid ? reg_rdata : 8'hxx; // Missing answer never matches
  endtask
endmodule
`default_nettype wire

// ---- testbench/drr_regs_sva.sv ----
// Checker for the address and reset control registers.
// Assumes drr_regs with its default address width.
`timescale 1ns/1ps
`default_nettype none
module drr_regs_sva (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       reg_wr_en,
  input wire logic       reg_wr_local,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [6:0] active_target_address,
  input wire logic       analog_power_down,
  input wire logic       logic_reset_pulse,
  input wire logic       register_reset_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Writes during a reset cycle start nothing
  wire w1 = reg_wr_en && reg_addr == 8'h01 && !logic_reset_pulse;
  property p_rst_addr; $rose(rst_b) |-> active_target_address == 7'h60; endproperty
  property p_sel; reg_wr_en && reg_addr == 8'h00 && reg_wdata[0] && !register_reset_pulse
    |-> ##2 active_target_address == $past(reg_wdata[7:1], 2); endproperty
  property p_pd; w1 && reg_wr_local && reg_wdata[5] && !reg_wdata[0] |-> ##2 analog_power_down; endproperty
  property p_remote; w1 && !reg_wr_local && !reg_wdata[0] |-> ##2 $stable(analog_power_down); endproperty
  property p_logic; w1 && reg_wdata[1:0] == 2'b10 |=> logic_reset_pulse && !register_reset_pulse; endproperty
  property p_full; w1 && reg_wdata[0] |=> register_reset_pulse && logic_reset_pulse; endproperty
  property p_self; logic_reset_pulse |=> !logic_reset_pulse; endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("address not 60 after reset");
  a_sel: assert property (p_sel) else $error("programmed address not used");
  a_pd: assert property (p_pd) else $error("power-down not set");
  a_remote: assert property (p_remote) else $error("remote write moved power-down");
  a_logic: assert property (p_logic) else $error("logic reset pulse wrong");
  a_full: assert property (p_full) else $error("full reset pulse wrong");
  a_self: assert property (p_self) else $error("reset pulse too long");
  c_full: cover property (register_reset_pulse);
  c_logic: cover property (logic_reset_pulse && !register_reset_pulse);
  c_pd: cover property (analog_power_down);
endmodule
bind drr_regs drr_regs_sva i_drr_regs_sva (.ref_clk, .rst_b, .reg_wr_en, .reg_wr_local, .reg_addr, .reg_wdata,
  .active_target_address, .analog_power_down, .logic_reset_pulse, .register_reset_pulse);
`default_nettype wire

// ---- testbench/drr_regs_test.sv ----
// Self-checking bench for the address and reset control registers.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module drr_regs_test;
  logic       ref_clk = 1'b0, rst_b = 1'b0, reg_wr_en, reg_wr_local, reg_rd_en, reg_rd_valid;
  logic       analog_power_down, logic_reset_pulse, register_reset_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [6:0] address_strap_input = 7'h2a, active_target_address;
  int         num_errors = 0, checks_done = 0, cyc = 0;
  int         logic_pulses = 0, full_pulses = 0;
  always @(posedge ref_clk) begin
    logic_pulses <= logic_pulses + int'(logic_reset_pulse);
    full_pulses  <= full_pulses + int'(register_reset_pulse);
  end
  initial forever #10 ref_clk = ~ref_clk;
  drr_host i_drr_host (.*);
  drr_regs i_drr_regs (.*);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_drr_host.rd(a, d);
    cmp(d, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 3000) begin
    num_errors++;
    stop_test();
  end
  task automatic t_address;
    rchk(8'h00, 8'hc0);
    rchk(8'h02, 8'h00);
    cmp({1'b0, active_target_address}, 8'h2a);
    i_drr_host.wr(8'h00, 8'ha5, 1'b1);
    rchk(8'h00, 8'ha5);
    address_strap_input = 7'h11;
    rchk(8'h00, 8'ha5);
    cmp({1'b0, active_target_address}, 8'h52);
    i_drr_host.wr(8'h00, 8'ha4, 1'b1);
    rchk(8'h00, 8'ha4);
    cmp({1'b0, active_target_address}, 8'h11);
    $display("address test done");
  endtask
  task automatic t_power;
    i_drr_host.wr(8'h01, 8'h20, 1'b0);
    rchk(8'h01, 8'h00);
    i_drr_host.wr(8'h01, 8'h20, 1'b1);
    rchk(8'h01, 8'h20);
    cmp({7'h00, analog_power_down}, 8'h01);
    i_drr_host.wr(8'h01, 8'h00, 1'b0);
    rchk(8'h01, 8'h20);
    $display("power test done");
  endtask
  task automatic t_resets;
    i_drr_host.wr(8'h01, 8'h22, 1'b1);
    rchk(8'h01, 8'h20);
    rchk(8'h00, 8'ha4);
    cmp(8'(logic_pulses), 8'h01);
    cmp(8'(full_pulses), 8'h00);
    i_drr_host.wr(8'h01, 8'h23, 1'b1);
    rchk(8'h00, 8'hc0);
    rchk(8'h01, 8'h00);
    cmp({7'h00, analog_power_down}, 8'h00);
    cmp(8'(logic_pulses), 8'h02);
    cmp(8'(full_pulses), 8'h01);
    $display("reset test done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    t_address();
    t_power();
    t_resets();
    stop_test();
  end
endmodule
`default_nettype wire
